// ===== ssmt_pkg.sv
// Shared constants and types of the serial master timing core.
// Assumes nothing of its surroundings; imported by ssmt_core.
package ssmt_pkg;

	localparam int DIV_W  = 10;
	localparam int QUANTUM_PRESCALE_W = 2;
	localparam int QUANTA_COUNT_W = 5;
	localparam int SRC_W  = 2;
	localparam int WLE_W  = 4;
	localparam int FLE_W  = 6;
	localparam int SEL_W  = 8;
	localparam int TCI_W  = 5;
	localparam int DATA_W = 16;

	localparam logic [3:0]        MODE_SSC = 4'h1;
	localparam logic [1:0]        TRM_DATA = 2'h1;
	localparam logic [FLE_W-1:0]  FLE_OPEN = 6'h3F;
	localparam logic [SEL_W-1:0]  SEL_RST  = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_LEAD  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_IWD   = 3'h3,
		ST_TRAIL = 3'h4,
		ST_NEXTF = 3'h5
	} ssmt_state_t;

endpackage

// ===== ssmt_core.sv
// Master timing core: shift clock, frame select with four delays, select
// outputs and a two-entry transmit word buffer.
// Assumes all inputs synchronous to clock and enable pulses one cycle wide.
//
// Function
// - Receive input switch at one takes received data from the pin.
// - Clock input switch at zero shifts on the internal clock, driven out.
// - Delays run only with frame select enabled; select switch zero uses it.
// - Receiving happens only while a word is being transmitted.
// - One data bit per shift clock period, no quanta involved.
// - Shift clock is input rate over two times divider plus one.
// - Phase preserve adds a further divide by two stage.
// - Leading delay and frame select start when a word is waiting.
// - First shift edge on the internal clock is rising, only after leading delay ends.
// - Trailing delay follows last clock; frame select drops at its end.
// - Without inter-word delay the next word follows with no gap.
// - With it, a pause without clocks, frame select held, between words.
// - Next-frame delay follows trailing delay, frame done at its end.
// - Select update mode lets first word control set select bits.
// - Leading and trailing delays share source, prescale and count.
// - Inter-word and next-frame delays share a second field group.
// - Delay lasts prescale plus one times count plus one quanta inputs.
// - Direct mode: a select line is active with frame select and its bit.
// - Coded mode: line zero lags frame select by one cycle.
// - Baud, frame length and protocol fields are frozen during a frame.
`timescale 1ns/1ps

module ssmt_core import ssmt_pkg::*; #(
	parameter int NQ = 4
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Mode and input stages
	input  wire logic [3:0]        channelMode,
	input  wire logic [1:0]        transferMode,
	input  wire logic              receiveInputSwitch,
	input  wire logic              clockInputSwitch,
	input  wire logic              selectInputSwitch,
	input  wire logic              frameSelectGenEnable,
	// Baud and frame format
	input  wire logic              phasePreserveEnable,
	input  wire logic [DIV_W-1:0]  clockDivideFactor,
	input  wire logic [WLE_W-1:0]  wordLength,
	input  wire logic [FLE_W-1:0]  frameLength,
	input  wire logic              interwordDelayEnable,
	// Select control
	input  wire logic              directSelectChoice,
	input  wire logic [SEL_W-1:0]  selectOutField,
	input  wire logic              selectUpdateMode,
	input  wire logic              lengthUpdateMode,
	input  wire logic              frameLengthUpdateMode,
	input  wire logic              writeAddressMode,
	// Delay field groups
	input  wire logic [SRC_W-1:0]  quantaSourceSelect,
	input  wire logic [QUANTUM_PRESCALE_W-1:0] quantumPrescale,
	input  wire logic [QUANTA_COUNT_W-1:0] quantaCount,
	input  wire logic [SRC_W-1:0]  quantaSourceSelectB,
	input  wire logic [QUANTUM_PRESCALE_W-1:0] quantumPrescaleB,
	input  wire logic [QUANTA_COUNT_W-1:0] quantaCountB,
	// Rate enables
	input  wire logic              pinEnable,
	input  wire logic [NQ-1:0]     quantaEnables,
	// Transmit words
	input  wire logic [DATA_W-1:0] txData,
	input  wire logic [TCI_W-1:0]  txControlInfo,
	input  wire logic              txValid,
	output logic                   txReady,
	// Pins
	input  wire logic              rxPin,
	input  wire logic              shiftClockIn,
	input  wire logic              selectInPin,
	output logic                   dataOut,
	output logic                   shiftClockOut,
	output logic [SEL_W-1:0]       selectOutLines,
	output logic                   masterFrameSelect,
	// Received words
	output logic [DATA_W-1:0]      rxWord,
	output logic                   rxWordValid
);

	ssmt_state_t state;
	logic                       frameSel;
	logic [TCI_W+DATA_W-1:0]    bufMem [2];
	logic                       wrPtr;
	logic                       rdPtr;
	logic [1:0]                 bufCount;
	logic [1:0]                 next_bufCount;
	logic [TCI_W+DATA_W-1:0]    bufHead;
	logic                       bufValid;
	logic                       push;
	logic                       wordLoad;
	logic                       enabled;
	logic                       frameStart;
	logic [DIV_W-1:0]           shDiv;
	logic                       shPpp;
	logic [FLE_W-1:0]           shFle;
	logic                       shTiwen;
	logic                       shDirect;
	logic [SEL_W-1:0]           shSel;
	logic [SRC_W-1:0]           shSrcA;
	logic [SRC_W-1:0]           shSrcB;
	logic [QUANTUM_PRESCALE_W-1:0]          shPreA;
	logic [QUANTUM_PRESCALE_W-1:0]          shPreB;
	logic [QUANTA_COUNT_W-1:0]          shCntA;
	logic [QUANTA_COUNT_W-1:0]          shCntB;
	logic [DIV_W+1:0]           halfLimit;
	logic [DIV_W+1:0]           halfCnt;
	logic                       halfTick;
	logic                       extPrev;
	logic                       shiftSel;
	logic                       rise;
	logic                       fall;
	logic [DATA_W-1:0]          shiftReg;
	logic [DATA_W-1:0]          rxShift;
	logic [WLE_W-1:0]           shWle;
	logic [WLE_W-1:0]           bitIdx;
	logic [FLE_W-1:0]           frameBits;
	logic                       lastBit;
	logic                       frameEnd;
	logic                       grpB;
	logic                       delayRun;
	logic                       delayDone;
	logic                       tick;
	logic [QUANTUM_PRESCALE_W-1:0]          preCnt;
	logic [QUANTA_COUNT_W-1:0]          qCnt;
	logic [QUANTUM_PRESCALE_W+QUANTA_COUNT_W:0]     leadTicks;

	assign enabled = channelMode == MODE_SSC && transferMode == TRM_DATA
		&& frameSelectGenEnable;
	assign frameStart = state == ST_IDLE && enabled && bufValid;

	// Two-entry word buffer; a stalled frame simply holds txReady low.
	assign push = txValid && txReady;
	assign bufValid = bufCount != 2'h0;
	assign bufHead = bufMem[rdPtr];
	assign next_bufCount = bufCount + 2'(push) - 2'(wordLoad);

	always_ff @(posedge clock) begin
		if (push) begin
			bufMem[wrPtr] <= {txControlInfo, txData};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			bufCount <= 2'h0;
			txReady <= 1'b1;
		end else begin
			wrPtr <= wrPtr ^ push;
			rdPtr <= rdPtr ^ wordLoad;
			bufCount <= next_bufCount;
			txReady <= next_bufCount != 2'h2;
		end
	end

	// Settings are captured once per frame so writes mid-frame wait.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shDiv <= '0;
			shPpp <= 1'b0;
			shFle <= FLE_OPEN;
			shTiwen <= 1'b0;
			shDirect <= 1'b0;
			shSel <= SEL_RST;
			shSrcA <= '0;
			shSrcB <= '0;
			shPreA <= '0;
			shPreB <= '0;
			shCntA <= '0;
			shCntB <= '0;
		end else if (frameStart) begin
			shDiv <= clockDivideFactor;
			shPpp <= phasePreserveEnable;
			shFle <= frameLength;
			shTiwen <= interwordDelayEnable;
			shDirect <= directSelectChoice;
			shSrcA <= quantaSourceSelect;
			shPreA <= quantumPrescale;
			shCntA <= quantaCount;
			shSrcB <= quantaSourceSelectB;
			shPreB <= quantumPrescaleB;
			shCntB <= quantaCountB;
			if (selectUpdateMode && !lengthUpdateMode
				&& !frameLengthUpdateMode && !writeAddressMode) begin
				shSel <= SEL_W'(bufHead[DATA_W +: TCI_W]);
			end else begin
				shSel <= selectOutField;
			end
		end
	end

	// Half period in input-rate pulses; no quanta counting here.
	assign halfLimit = ({2'b00, shDiv} + (DIV_W+2)'(1))
		<< shPpp;
	assign halfTick = state == ST_SHIFT && pinEnable
		&& halfCnt == halfLimit - 1'b1;

	always_ff @(posedge clock) begin
		if (sys_rst || state != ST_SHIFT || halfTick) begin
			halfCnt <= '0;
		end else if (pinEnable) begin
			halfCnt <= halfCnt + 1'b1;
		end
	end

	// Clock idles low, so the first edge of every word is rising.
	always_ff @(posedge clock) begin
		if (sys_rst || state != ST_SHIFT) begin
			shiftClockOut <= 1'b0;
		end else if (halfTick) begin
			shiftClockOut <= !shiftClockOut;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			extPrev <= 1'b0;
		end else begin
			extPrev <= shiftClockIn;
		end
	end

	// An external clock never edging leaves the frame waiting.
	assign shiftSel = selectInputSwitch ? selectInPin : frameSel;
	assign rise = shiftSel && state == ST_SHIFT && (clockInputSwitch
		? shiftClockIn && !extPrev : halfTick && !shiftClockOut);
	assign fall = shiftSel && state == ST_SHIFT && (clockInputSwitch
		? !shiftClockIn && extPrev : halfTick && shiftClockOut);
	assign lastBit = bitIdx == shWle;
	assign frameEnd = shFle != FLE_OPEN && frameBits == shFle;
	assign wordLoad = ((state == ST_LEAD || state == ST_IWD) && delayDone)
		|| (fall && lastBit && !frameEnd && bufValid && !shTiwen);

	always_ff @(posedge clock) begin
		if (sys_rst || !enabled) begin
			state <= ST_IDLE;
			frameSel <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (bufValid) begin
						state <= ST_LEAD;
						frameSel <= 1'b1;
					end
				end
				ST_LEAD: begin
					if (delayDone) begin
						state <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (fall && (frameEnd || lastBit && !bufValid)) begin
						state <= ST_TRAIL;
					end else if (fall && lastBit && shTiwen) begin
						state <= ST_IWD;
					end
				end
				ST_IWD: begin
					if (delayDone) begin
						state <= ST_SHIFT;
					end
				end
				ST_TRAIL: begin
					if (delayDone) begin
						state <= ST_NEXTF;
						frameSel <= 1'b0;
					end
				end
				ST_NEXTF: begin
					if (delayDone) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Shift unit, LSB first; receive only samples inside a sent word.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			shiftReg <= DATA_RST;
			rxShift <= DATA_RST;
			rxWord <= DATA_RST;
			rxWordValid <= 1'b0;
			dataOut <= 1'b0;
			shWle <= '0;
			bitIdx <= '0;
			frameBits <= '0;
		end else begin
			rxWordValid <= fall && (lastBit || frameEnd);
			if (fall && (lastBit || frameEnd)) begin
				rxWord <= rxShift >> (WLE_W'(DATA_W - 1) - bitIdx);
			end
			if (rise) begin
				rxShift <= {receiveInputSwitch ? rxPin : dataOut,
					rxShift[DATA_W-1:1]};
			end
			if (frameStart) begin
				frameBits <= '0;
			end else if (fall) begin
				frameBits <= frameBits + 1'b1;
			end
			if (wordLoad) begin
				shiftReg <= bufHead[DATA_W-1:0];
				dataOut <= bufHead[0];
				shWle <= wordLength;
				bitIdx <= '0;
			end else if (fall) begin
				shiftReg <= shiftReg >> 1;
				dataOut <= shiftReg[1];
				bitIdx <= bitIdx + 1'b1;
			end
		end
	end

	// One quanta engine serves both groups; the state picks the group.
	assign grpB = state == ST_IWD || state == ST_NEXTF;
	assign delayRun = state != ST_IDLE && state != ST_SHIFT;
	assign tick = quantaEnables[grpB ? shSrcB : shSrcA];
	assign delayDone = delayRun && tick
		&& preCnt == (grpB ? shPreB : shPreA)
		&& qCnt == (grpB ? shCntB : shCntA);

	always_ff @(posedge clock) begin
		if (sys_rst || !delayRun || delayDone) begin
			preCnt <= '0;
			qCnt <= '0;
		end else if (tick) begin
			if (preCnt == (grpB ? shPreB : shPreA)) begin
				preCnt <= '0;
				qCnt <= qCnt + 1'b1;
			end else begin
				preCnt <= preCnt + 1'b1;
			end
		end
	end

	// Output stage; coded line zero lags so the address lines settle.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			masterFrameSelect <= 1'b0;
			selectOutLines <= SEL_RST;
		end else begin
			masterFrameSelect <= frameSel;
			if (shDirect) begin
				selectOutLines <= {SEL_W{frameSel}} & shSel;
			end else begin
				selectOutLines <= {shSel[SEL_W-1:1],
					masterFrameSelect & shSel[0]};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || state != ST_LEAD) begin
			leadTicks <= '0;
		end else if (tick) begin
			leadTicks <= leadTicks + 1'b1;
		end
	end

	property p_lead_start;
		@(posedge clock) disable iff (sys_rst)
		$rose(frameSel) |-> state == ST_LEAD && $past(bufValid);
	endproperty
	a_lead_start: assert property (p_lead_start)
		else $error("frame select rose outside a leading delay");

	property p_lead_quiet;
		@(posedge clock) disable iff (sys_rst)
		state == ST_LEAD |=> !shiftClockOut;
	endproperty
	a_lead_quiet: assert property (p_lead_quiet)
		else $error("shift clock moved during leading delay");

	property p_trail_end;
		@(posedge clock) disable iff (sys_rst)
		$fell(frameSel) && enabled |-> $past(state) == ST_TRAIL
			&& state == ST_NEXTF;
	endproperty
	a_trail_end: assert property (p_trail_end)
		else $error("frame select fell outside trailing delay end");

	property p_iwd_hold;
		@(posedge clock) disable iff (sys_rst)
		state == ST_IWD |-> frameSel && !shiftClockOut;
	endproperty
	a_iwd_hold: assert property (p_iwd_hold)
		else $error("inter-word delay lost frame select or clocked");

	property p_nextf_quiet;
		@(posedge clock) disable iff (sys_rst)
		state == ST_NEXTF |-> !frameSel && !shiftClockOut;
	endproperty
	a_nextf_quiet: assert property (p_nextf_quiet)
		else $error("next-frame delay shows select or clock");

	property p_no_gap;
		@(posedge clock) disable iff (sys_rst)
		fall && lastBit && !frameEnd && bufValid && !shTiwen
			|=> state == ST_SHIFT && bitIdx == '0;
	endproperty
	a_no_gap: assert property (p_no_gap)
		else $error("gap between words without inter-word delay");

	property p_rx_in_word;
		@(posedge clock) disable iff (sys_rst)
		rxWordValid |-> $past(state) == ST_SHIFT;
	endproperty
	a_rx_in_word: assert property (p_rx_in_word)
		else $error("received word outside a transmitted word");

	property p_lead_len;
		@(posedge clock) disable iff (sys_rst)
		state == ST_LEAD && delayDone |-> int'(leadTicks) + 1
			== (int'(shPreA) + 1) * (int'(shCntA) + 1);
	endproperty
	a_lead_len: assert property (p_lead_len)
		else $error("leading delay length wrong");

	property p_direct_sel;
		@(posedge clock) disable iff (sys_rst)
		shDirect && $past(shDirect)
			|-> (selectOutLines & ~{SEL_W{masterFrameSelect}}) == '0;
	endproperty
	a_direct_sel: assert property (p_direct_sel)
		else $error("direct select line active without frame select");

	property p_coded_lag;
		@(posedge clock) disable iff (sys_rst)
		!shDirect && $past(!shDirect) |-> selectOutLines[0]
			== ($past(masterFrameSelect) && $past(shSel[0]));
	endproperty
	a_coded_lag: assert property (p_coded_lag)
		else $error("coded enable line not one cycle behind");

	c_frame_done: cover property (@(posedge clock)
		state == ST_NEXTF && delayDone);
	c_interword: cover property (@(posedge clock) state == ST_IWD);
	c_back_to_back: cover property (@(posedge clock)
		fall && lastBit && wordLoad);
	c_buffer_full: cover property (@(posedge clock) !txReady && txValid);

endmodule

// ===== ssmt_slave_model.sv
// Behavioural serial slave that faces the master timing core.
// Assumes an active high select line and a clock shared with the master.
`timescale 1ns/1ps

module ssmt_slave_model #(
	parameter logic [15:0] REPLY = 16'h5A96
) (
	// Clock and reset
	input  wire logic   clock,
	input  wire logic   sys_rst,
	// Serial pins
	input  wire logic   sclk,
	input  wire logic   sel,
	input  wire logic   mosi,
	output logic        miso,
	// Last sixteen bits taken in
	output logic [15:0] got
);
	logic       prevSclk;
	logic       prevSel;
	logic [3:0] bitIdx;

	always_ff @(posedge clock) begin
		prevSclk <= sclk;
		prevSel  <= sel;
		if (sys_rst) begin
			miso   <= 1'b0;
			got    <= 16'h0000;
			bitIdx <= 4'h0;
		end else if (!sel) begin
			// Released, the line shows the inverse of its last bit.
			if (prevSel)
				miso <= ~miso;
		end else if (!prevSel) begin
			miso   <= REPLY[0];
			bitIdx <= 4'h1;
		end else begin
			if (sclk && !prevSclk)
				got <= {mosi, got[15:1]};
			if (!sclk && prevSclk) begin
				miso   <= REPLY[bitIdx];
				bitIdx <= bitIdx + 4'h1;
			end
		end
	end
endmodule

// ===== test_sync_serial_master_timing.sv
// Self-checking bench for the serial master timing core with a slave model.
// Assumes a 40 MHz clock; the slave listens on select line zero.
`timescale 1ns/1ps

module test_sync_serial_master_timing import ssmt_pkg::*;;

	logic              clock                 = 1'b0;
	logic              sys_rst               = 1'b1;
	logic [3:0]        channelMode           = 4'h0;
	logic [1:0]        transferMode          = 2'h1;
	logic              receiveInputSwitch    = 1'b0;
	logic              clockInputSwitch      = 1'b1;
	logic              selectInputSwitch     = 1'b1;
	logic              frameSelectGenEnable  = 1'b1;
	logic              phasePreserveEnable   = 1'b0;
	logic [DIV_W-1:0]  clockDivideFactor     = 10'h001;
	logic [WLE_W-1:0]  wordLength            = 4'h7;
	logic [FLE_W-1:0]  frameLength           = 6'h0F;
	logic              interwordDelayEnable  = 1'b0;
	logic              directSelectChoice    = 1'b1;
	logic [SEL_W-1:0]  selectOutField        = 8'h01;
	logic              selectUpdateMode      = 1'b0;
	logic              lengthUpdateMode      = 1'b0;
	logic              frameLengthUpdateMode = 1'b0;
	logic              writeAddressMode      = 1'b0;
	logic [SRC_W-1:0]  quantaSourceSelect    = 2'h0;
	logic [QUANTUM_PRESCALE_W-1:0] quantumPrescale       = 2'h2;
	logic [QUANTA_COUNT_W-1:0] quantaCount           = 5'h03;
	logic [SRC_W-1:0]  quantaSourceSelectB   = 2'h0;
	logic [QUANTUM_PRESCALE_W-1:0] quantumPrescaleB      = 2'h1;
	logic [QUANTA_COUNT_W-1:0] quantaCountB          = 5'h01;
	logic              pinEnable             = 1'b0;
	logic              tick3                 = 1'b0;
	logic [DATA_W-1:0] txData                = 16'h0000;
	logic [TCI_W-1:0]  txControlInfo         = 5'h00;
	logic              txValid               = 1'b0;
	logic              shiftClockIn          = 1'b0;
	logic              selectInPin           = 1'b0;
	logic [SEL_W-1:0]  expSel                = 8'h01;
	logic [TCI_W-1:0]  firstTci              = 5'h00;
	logic              pSclk                 = 1'b0;
	logic              pMfs                  = 1'b0;
	logic              txReady;
	logic              rxPin;
	logic              dataOut;
	logic              shiftClockOut;
	logic [SEL_W-1:0]  selectOutLines;
	logic              masterFrameSelect;
	logic [DATA_W-1:0] rxWord;
	logic              rxWordValid;
	logic [15:0]       slaveGot;
	int                cyc                   = 0;
	int                miscompares           = 0;
	int                num_checks            = 0;
	int                riseQ[$];
	int                fallQ[$];
	int                onQ[$];
	int                offQ[$];
	logic [DATA_W-1:0] rxQ[$];

	always #12.5 clock = ~clock;

	ssmt_core #(.NQ(4)) dut_u (
		.clock, .sys_rst, .channelMode, .transferMode, .receiveInputSwitch,
		.clockInputSwitch, .selectInputSwitch, .frameSelectGenEnable,
		.phasePreserveEnable, .clockDivideFactor, .wordLength, .frameLength,
		.interwordDelayEnable, .directSelectChoice, .selectOutField,
		.selectUpdateMode, .lengthUpdateMode, .frameLengthUpdateMode,
		.writeAddressMode, .quantaSourceSelect, .quantumPrescale,
		.quantaCount, .quantaSourceSelectB, .quantumPrescaleB, .quantaCountB,
		.pinEnable, .quantaEnables({tick3, tick3, pinEnable, 1'b1}),
		.txData, .txControlInfo, .txValid, .txReady, .rxPin, .shiftClockIn,
		.selectInPin, .dataOut, .shiftClockOut, .selectOutLines,
		.masterFrameSelect, .rxWord, .rxWordValid
	);

	ssmt_slave_model slv_u (
		.clock, .sys_rst, .sclk(shiftClockOut), .sel(selectOutLines[0]),
		.mosi(dataOut), .miso(rxPin), .got(slaveGot)
	);

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (num_checks > 0 && miscompares == 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Rate pulses follow the cycle count so every frame starts in phase.
	always @(posedge clock) begin
		#1;
		pinEnable = (cyc % 2 == 0);
		tick3 = (cyc % 3 == 0);
		// Unused pins wiggle so that a wrong input choice shows up.
		shiftClockIn = ~shiftClockIn;
		selectInPin = ~selectInPin;
	end

	always @(posedge clock) begin
		cyc = cyc + 1;
		if (shiftClockOut && !pSclk)
			riseQ.push_back(cyc);
		if (!shiftClockOut && pSclk)
			fallQ.push_back(cyc);
		if (masterFrameSelect && !pMfs)
			onQ.push_back(cyc);
		if (!masterFrameSelect && pMfs)
			offQ.push_back(cyc);
		if (rxWordValid === 1'b1)
			rxQ.push_back(rxWord);
		if (!sys_rst && directSelectChoice)
			check("select", 32'(selectOutLines),
				32'(masterFrameSelect ? expSel : SEL_RST));
		if (!sys_rst && !directSelectChoice)
			check("dec enable", 32'(selectOutLines),
				32'({expSel[SEL_W-1:1], pMfs & expSel[0]}));
		pSclk = shiftClockOut;
		pMfs = masterFrameSelect;
		if (cyc > 30000) begin
			miscompares++;
			end_sim();
		end
	end

	function automatic logic [7:0] wd(int i);
		return 8'h3C + 8'(i * 17);
	endfunction

	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic push(int i);
		int k;
		txData = {8'h00, wd(i)};
		txControlInfo = i[0] ? 5'h0B : firstTci;
		txValid = 1'b1;
		@(posedge clock);
		for (k = 0; k < 3000 && txReady !== 1'b1; k++)
			@(posedge clock);
		#1;
	endtask

	task automatic clear;
		riseQ.delete();
		fallQ.delete();
		onQ.delete();
		offQ.delete();
		rxQ.delete();
	endtask

	task automatic settle(int n);
		int k;
		for (k = 0; k < 6000 && rxQ.size() < n; k++)
			tick(1);
		for (k = 0; k < 600 && masterFrameSelect !== 1'b0; k++)
			tick(1);
		tick(200);
	endtask

	task automatic run(int n, int midDiv);
		int k;
		clear();
		while (cyc % 12 != 0)
			tick(1);
		fork
			begin
				for (int i = 0; i < n; i++)
					push(i);
				txValid = 1'b0;
			end
			if (midDiv > 0) begin
				for (k = 0; k < 3000 && riseQ.size() < 2; k++)
					tick(1);
				clockDivideFactor = DIV_W'(midDiv);
			end
		join
		settle(n);
	endtask

	task automatic basic(int n, int per);
		check("rises", riseQ.size(), 8 * n);
		check("period", riseQ[1] - riseQ[0], per);
		check("high half", fallQ[0] - riseQ[0], per / 2);
		check("last period", riseQ[8*n-1] - riseQ[8*n-2], per);
		if (!interwordDelayEnable)
			check("word joint", riseQ[8] - riseQ[7], per);
		check("slave data", 32'(slaveGot), 32'({wd(n-1), wd(n-2)}));
		for (int i = 0; i < n; i++)
			check("rx byte", 32'(rxQ[i][7:0]), i[0] ? 32'h5A : 32'h96);
	endtask

	task automatic buffer_test;
		clear();
		transferMode = 2'h0;
		push(0);
		push(1);
		txData = 16'h00FF;
		tick(6);
		check("full", 32'(txReady), 0);
		txValid = 1'b0;
		check("no frame", onQ.size(), 0);
		transferMode = TRM_DATA;
		frameSelectGenEnable = 1'b0;
		tick(40);
		check("no select gen", onQ.size(), 0);
		frameSelectGenEnable = 1'b1;
		settle(2);
		basic(2, 8);
		check("refused word", rxQ.size(), 2);
		$display("test buffer done");
	endtask

	task automatic lead_test;
		int ld[2];
		int tr[2];
		int d;
		for (int s = 0; s < 3; s += 2) begin
			quantaSourceSelect = SRC_W'(s);
			quantumPrescale = s ? 2'h0 : 2'h2;
			d = (quantumPrescale + 1) * 4 * (s ? 3 : 1);
			for (int j = 0; j < 2; j++) begin
				quantaCount = j ? 5'h07 : 5'h03;
				run(2, 0);
				basic(2, 8);
				ld[j] = riseQ[0] - onQ[0];
				tr[j] = offQ[0] - fallQ[15];
			end
			check("lead step", ld[1] - ld[0], d);
			check("trail step", tr[1] - tr[0], d);
			check("lead length", 32'(ld[0] + 2 >= d), 1);
		end
		$display("test leading and trailing done");
	endtask

	task automatic group_b_test;
		int gp[2];
		int nf[2];
		interwordDelayEnable = 1'b1;
		for (int j = 0; j < 2; j++) begin
			quantaCountB = j ? 5'h05 : 5'h01;
			run(4, 0);
			basic(4, 8);
			check("frames", onQ.size(), 2);
			gp[j] = riseQ[8] - riseQ[7];
			nf[j] = onQ[1] - offQ[0];
		end
		check("gap step", gp[1] - gp[0], 8);
		check("gap present", 32'(gp[0] > 8), 1);
		check("next frame step", nf[1] - nf[0], 8);
		interwordDelayEnable = 1'b0;
		$display("test inter-word and next-frame done");
	endtask

	task automatic misc_test;
		// Loopback is chosen with the channel off, like any input stage.
		channelMode = 4'h0;
		receiveInputSwitch = 1'b0;
		tick(2);
		channelMode = MODE_SSC;
		run(2, 0);
		for (int i = 0; i < 2; i++)
			check("loop byte", 32'(rxQ[i][7:0]), 32'(wd(i)));
		channelMode = 4'h0;
		receiveInputSwitch = 1'b1;
		tick(2);
		channelMode = MODE_SSC;
		phasePreserveEnable = 1'b1;
		directSelectChoice = 1'b0;
		run(2, 0);
		basic(2, 16);
		phasePreserveEnable = 1'b0;
		directSelectChoice = 1'b1;
		run(2, 3);
		basic(2, 8);
		clockDivideFactor = 10'h001;
		selectUpdateMode = 1'b1;
		firstTci = 5'h15;
		expSel = 8'h15;
		run(2, 0);
		basic(2, 8);
		// Length update mode set must keep the programmed select setting.
		lengthUpdateMode = 1'b1;
		expSel = 8'h01;
		run(2, 0);
		basic(2, 8);
		lengthUpdateMode = 1'b0;
		$display("test phase, coded, shadow and update done");
	endtask

	initial begin
		tick(12);
		sys_rst = 1'b0;
		// Input stages are chosen while the channel is still off.
		receiveInputSwitch = 1'b1;
		clockInputSwitch = 1'b0;
		selectInputSwitch = 1'b0;
		tick(2);
		channelMode = MODE_SSC;
		buffer_test();
		lead_test();
		group_b_test();
		misc_test();
		end_sim();
	end
endmodule
